/* File: charger_fault_flag_mask_bank.v */
// The third charger event flag register, the fault flag registers and the first interrupt mask register.
// Assumes an external serial-bus slave presents a one-cycle register read or write strobe.
//
// Summary of operation
// [R1] Bit 4 of third charger flags reports battery too low for reverse boost.
// [R2] Third charger flags bit 3 sets on cold crossing, bit 2 on cool crossing.
// [R3] Third charger flags bit 1 sets on warm crossing, bit 0 on hot crossing.
// [R4] First fault flags bit 7 sets on entering or leaving battery current regulation.
// [R5] First fault flags bit 6 sets on entering bus over-voltage protection.
// [R6] First fault flags bit 5 sets on entering battery over-voltage protection.
// [R7] First fault flags bit 4 sets on entering bus over-current protection.
// [R8] First fault flags bit 3 sets on entering discharge over-current protection.
// [R9] First fault flags bit 2 sets on entering converter over-current protection.
// [R10] First fault flags bit 1 second input, bit 0 first input over-voltage.
// [R11] Second fault flags bit 7 sets when switching stops on system short.
// [R12] Second fault flags bit 6 sets when switching stops on system over-voltage.
// [R13] Second fault flags bit 5 sets when boost stops on bus over-voltage.
// [R14] Second fault flags bit 4 sets when boost stops on bus under-voltage.
// [R15] Second fault flags bit 2 sets on thermal shutdown rising edge.
// [R16] Mask bit 7 clear lets input or boost current regulation entry pulse interrupt.
// [R17] Mask bit 6 clear lets input or boost voltage regulation entry pulse interrupt.
// [R18] Mask bit 5 clear lets watchdog expiry pulse the interrupt.
// [R19] Poor source interrupts unless mask bit 4; power-good toggle unless mask bit 3.
// [R20] Presence changes of inputs and bus interrupt unless mask bits 2, 1, 0 set.
// [R21] Flags clear at power-on; masks clear at power-on and register reset.
// [R22] Unmasked events merge into one interrupt pulse; reserved bits read zero.
`default_nettype none
`include "flag_mask_regs.vh"

module charger_fault_flag_mask_bank #(
  parameter IRQ_CYCLES = `IRQ_PULSE_CYCLES
) (
  input wire ref_clk,
  input wire reset_n,
  // Register access from the serial-bus slave.
  input wire [7:0] reg_addr,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_wdata,
  input wire register_reset,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  // Analog monitor levels, asynchronous to ref_clk.
  input wire battery_low_for_boost,
  input wire thermistor_cold,
  input wire thermistor_cool,
  input wire thermistor_warm,
  input wire thermistor_hot,
  input wire battery_current_regulation,
  input wire bus_overvoltage,
  input wire battery_overvoltage,
  input wire bus_overcurrent,
  input wire discharge_overcurrent,
  input wire converter_overcurrent,
  input wire second_input_overvoltage,
  input wire first_input_overvoltage,
  input wire system_short,
  input wire system_overvoltage,
  input wire boost_overvoltage,
  input wire boost_undervoltage,
  input wire die_thermal_shutdown,
  input wire input_current_limit,
  input wire input_voltage_limit,
  input wire watchdog_expired,
  input wire weak_source,
  input wire power_good,
  input wire second_input_present,
  input wire first_input_present,
  input wire bus_present,
  // Interrupt output toward the host, active low pulse.
  output wire irq_n
);

  // ==========================================================================
  // Synchronise all monitor levels and detect their edges.
  wire [25:0] levels;
  wire [25:0] rise;
  wire [25:0] change;

  // Position of each monitor level within the synchronised vector.
  localparam BATTERY_LOW_IDX = 25;
  localparam COLD_IDX = 24;
  localparam COOL_IDX = 23;
  localparam WARM_IDX = 22;
  localparam HOT_IDX = 21;
  localparam CURRENT_REGULATION_IDX = 20;
  localparam BUS_OV_IDX = 19;
  localparam BATTERY_OV_IDX = 18;
  localparam BUS_OC_IDX = 17;
  localparam DISCHARGE_OC_IDX = 16;
  localparam CONVERTER_OC_IDX = 15;
  localparam SECOND_INPUT_OV_IDX = 14;
  localparam FIRST_INPUT_OV_IDX = 13;
  localparam SYSTEM_SHORT_IDX = 12;
  localparam SYSTEM_OV_IDX = 11;
  localparam BOOST_OV_IDX = 10;
  localparam BOOST_UV_IDX = 9;
  localparam THERMAL_SHUTDOWN_IDX = 8;
  localparam INPUT_CURRENT_LIMIT_IDX = 7;
  localparam INPUT_VOLTAGE_LIMIT_IDX = 6;
  localparam WATCHDOG_IDX = 5;
  localparam WEAK_SOURCE_IDX = 4;
  localparam POWER_GOOD_IDX = 3;
  localparam SECOND_PRESENT_IDX = 2;
  localparam FIRST_PRESENT_IDX = 1;
  localparam BUS_PRESENT_IDX = 0;

  assign levels = {battery_low_for_boost, thermistor_cold, thermistor_cool, thermistor_warm, thermistor_hot,
                   battery_current_regulation, bus_overvoltage, battery_overvoltage, bus_overcurrent,
                   discharge_overcurrent, converter_overcurrent, second_input_overvoltage,
                   first_input_overvoltage, system_short, system_overvoltage, boost_overvoltage,
                   boost_undervoltage, die_thermal_shutdown, input_current_limit, input_voltage_limit,
                   watchdog_expired, weak_source, power_good, second_input_present,
                   first_input_present, bus_present};

  edge_sync #(
    .WIDTH(26)
  ) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .level_in(levels),
    .rise(rise),
    .change(change)
  );

  // ==========================================================================
  // Event vectors aligned to register bit positions.
  wire [7:0] flags_three_set;
  wire [7:0] fault_zero_set;
  wire [7:0] fault_one_set;
  wire [7:0] mask_events;

  // Battery low and thermistor zone crossings; thermistor crossings count both ways, battery low only on rising.
  assign flags_three_set[7:5] = 3'h0;
  assign flags_three_set[`BATTERY_LOW_FOR_BOOST_BIT] = rise[BATTERY_LOW_IDX]; // [R1]
  assign flags_three_set[`THERMISTOR_COLD_BIT] = change[COLD_IDX]; // [R2]
  assign flags_three_set[`THERMISTOR_COOL_BIT] = change[COOL_IDX]; // [R2]
  assign flags_three_set[`THERMISTOR_WARM_BIT] = change[WARM_IDX]; // [R3]
  assign flags_three_set[`THERMISTOR_HOT_BIT] = change[HOT_IDX]; // [R3]

  // Regulation flag catches entry and exit; protection flags catch entry only.
  assign fault_zero_set[`BATTERY_CURRENT_REGULATION_BIT] = change[CURRENT_REGULATION_IDX]; // [R4]
  assign fault_zero_set[`BUS_OVERVOLTAGE_BIT] = rise[BUS_OV_IDX]; // [R5]
  assign fault_zero_set[`BATTERY_OVERVOLTAGE_BIT] = rise[BATTERY_OV_IDX]; // [R6]
  assign fault_zero_set[`BUS_OVERCURRENT_BIT] = rise[BUS_OC_IDX]; // [R7]
  assign fault_zero_set[`DISCHARGE_OVERCURRENT_BIT] = rise[DISCHARGE_OC_IDX]; // [R8]
  assign fault_zero_set[`CONVERTER_OVERCURRENT_BIT] = rise[CONVERTER_OC_IDX]; // [R9]
  assign fault_zero_set[`SECOND_INPUT_OVERVOLTAGE_BIT] = rise[SECOND_INPUT_OV_IDX]; // [R10]
  assign fault_zero_set[`FIRST_INPUT_OVERVOLTAGE_BIT] = rise[FIRST_INPUT_OV_IDX]; // [R10]

  // Stops of switching or boost output and thermal shutdown.
  assign fault_one_set[`SYSTEM_SHORT_BIT] = rise[SYSTEM_SHORT_IDX]; // [R11]
  assign fault_one_set[`SYSTEM_OVERVOLTAGE_BIT] = rise[SYSTEM_OV_IDX]; // [R12]
  assign fault_one_set[`BOOST_OVERVOLTAGE_BIT] = rise[BOOST_OV_IDX]; // [R13]
  assign fault_one_set[`BOOST_UNDERVOLTAGE_BIT] = rise[BOOST_UV_IDX]; // [R14]
  assign fault_one_set[3] = 1'b0;
  assign fault_one_set[`DIE_THERMAL_SHUTDOWN_BIT] = rise[THERMAL_SHUTDOWN_IDX]; // [R15]
  assign fault_one_set[1:0] = 2'h0;

  // Events gated by the first mask register, in its bit order.
  assign mask_events[`INPUT_CURRENT_LIMIT_MASK_BIT] = rise[INPUT_CURRENT_LIMIT_IDX]; // [R16]
  assign mask_events[`INPUT_VOLTAGE_LIMIT_MASK_BIT] = rise[INPUT_VOLTAGE_LIMIT_IDX]; // [R17]
  assign mask_events[`WATCHDOG_EXPIRY_MASK_BIT] = rise[WATCHDOG_IDX]; // [R18]
  assign mask_events[`WEAK_SOURCE_MASK_BIT] = rise[WEAK_SOURCE_IDX]; // [R19]
  assign mask_events[`POWER_GOOD_MASK_BIT] = change[POWER_GOOD_IDX]; // [R19]
  assign mask_events[`SECOND_INPUT_PRESENCE_MASK_BIT] = change[SECOND_PRESENT_IDX]; // [R20]
  assign mask_events[`FIRST_INPUT_PRESENCE_MASK_BIT] = change[FIRST_PRESENT_IDX]; // [R20]
  assign mask_events[`BUS_PRESENCE_MASK_BIT] = change[BUS_PRESENT_IDX]; // [R20]

  // ==========================================================================
  // Registers.
  reg [7:0] flags_three_q;
  reg [7:0] fault_zero_q;
  reg [7:0] fault_one_q;
  reg [7:0] mask_zero_q;
  reg [7:0] flags_three_d;
  reg [7:0] fault_zero_d;
  reg [7:0] fault_one_d;
  reg [7:0] mask_zero_d;

  // Address match shared by the clearing reads, the mask write and the read mux.
  function addr_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // Clear-on-read helper; a set in the same cycle as the clearing read wins.
  function [7:0] flag_next;
    input [7:0] cur;
    input [7:0] set;
    input [7:0] used;
    input clr;
    begin
      flag_next = ((clr ? 8'h00 : cur) | set) & used;
    end
  endfunction

  // Next-state logic for flags and mask.
  always @*
  begin
    flags_three_d = flag_next(flags_three_q, flags_three_set, `FLAGS_THREE_USED, // [R22]
                              reg_read && addr_hit(reg_addr, `CHARGER_EVENT_FLAGS_THREE_ADDR));
    fault_zero_d = flag_next(fault_zero_q, fault_zero_set, `FAULT_ZERO_USED,
                             reg_read && addr_hit(reg_addr, `FAULT_EVENT_FLAGS_ZERO_ADDR));
    fault_one_d = flag_next(fault_one_q, fault_one_set, `FAULT_ONE_USED, // [R22]
                            reg_read && addr_hit(reg_addr, `FAULT_EVENT_FLAGS_ONE_ADDR));
    mask_zero_d = mask_zero_q;
    if (register_reset)
    begin
      mask_zero_d = `MASK_RESET; // [R21]
    end
    else if (reg_write && addr_hit(reg_addr, `CHARGER_INTERRUPT_MASK_ZERO_ADDR))
    begin
      mask_zero_d = reg_wdata;
    end
  end

  // Flag and mask storage; power-on reset clears all.
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flags_three_q <= `FLAGS_RESET; // [R21]
      fault_zero_q <= `FLAGS_RESET;
      fault_one_q <= `FLAGS_RESET;
      mask_zero_q <= `MASK_RESET;
    end
    else
    begin
      flags_three_q <= flags_three_d;
      fault_zero_q <= fault_zero_d;
      fault_one_q <= fault_one_d;
      mask_zero_q <= mask_zero_d;
    end
  end

  // ==========================================================================
  // Read data path; unmapped addresses read zero.
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_read;
      if (!reg_read)
      begin
        reg_rdata <= reg_rdata;
      end
      else if (addr_hit(reg_addr, `CHARGER_EVENT_FLAGS_THREE_ADDR))
      begin
        reg_rdata <= flags_three_q;
      end
      else if (addr_hit(reg_addr, `FAULT_EVENT_FLAGS_ZERO_ADDR))
      begin
        reg_rdata <= fault_zero_q;
      end
      else if (addr_hit(reg_addr, `FAULT_EVENT_FLAGS_ONE_ADDR))
      begin
        reg_rdata <= fault_one_q;
      end
      else if (addr_hit(reg_addr, `CHARGER_INTERRUPT_MASK_ZERO_ADDR))
      begin
        reg_rdata <= mask_zero_q;
      end
      else
      begin
        reg_rdata <= 8'h00; // [R22]
      end
    end
  end

  // ==========================================================================
  // Interrupt request: unmasked mask-bank events plus all flag-setting events.
  wire mask_bank_hit;
  wire flag_bank_hit;
  reg irq_req_q;

  // Mask-bank events pass only where their mask bit is clear; flag events always pass.
  assign mask_bank_hit = |(mask_events & ~mask_zero_q); // [R16] [R17] [R18] [R19] [R20]
  assign flag_bank_hit = (|flags_three_set) | (|fault_zero_set) | (|fault_one_set); // [R22]

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_req_q <= 1'b0;
    end
    else
    begin
      irq_req_q <= mask_bank_hit | flag_bank_hit; // [R22]
    end
  end

  irq_pulser #(
    .CYCLES(IRQ_CYCLES)
  ) u_pulse (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .request(irq_req_q),
    .irq_n(irq_n)
  );

endmodule // charger_fault_flag_mask_bank

`default_nettype wire

/* File: flag_mask_regs.vh */
// Register offsets, field positions and timing constants for the charger flag and mask bank.
// Assumes the includer uses 8-bit register addresses and 8-bit register data.
`ifndef FLAG_MASK_REGS_VH
`define FLAG_MASK_REGS_VH

// ==========================================================================
// Register offsets
`define CHARGER_EVENT_FLAGS_THREE_ADDR 8'h25
`define FAULT_EVENT_FLAGS_ZERO_ADDR 8'h26
`define FAULT_EVENT_FLAGS_ONE_ADDR 8'h27
`define CHARGER_INTERRUPT_MASK_ZERO_ADDR 8'h28

// ==========================================================================
// Reset values
`define FLAGS_RESET 8'h00
`define MASK_RESET 8'h00

// ==========================================================================
// Implemented bits of each flag register (reserved bits read zero)
`define FLAGS_THREE_USED 8'h1f
`define FAULT_ZERO_USED 8'hff
`define FAULT_ONE_USED 8'hf4

// Field positions in the third charger flag register.
`define BATTERY_LOW_FOR_BOOST_BIT 4
`define THERMISTOR_COLD_BIT 3
`define THERMISTOR_COOL_BIT 2
`define THERMISTOR_WARM_BIT 1
`define THERMISTOR_HOT_BIT 0

// Field positions in the second fault flag register.
`define SYSTEM_SHORT_BIT 7
`define SYSTEM_OVERVOLTAGE_BIT 6
`define BOOST_OVERVOLTAGE_BIT 5
`define BOOST_UNDERVOLTAGE_BIT 4
`define DIE_THERMAL_SHUTDOWN_BIT 2

// Field positions in the first fault flag register.
`define BATTERY_CURRENT_REGULATION_BIT 7
`define BUS_OVERVOLTAGE_BIT 6
`define BATTERY_OVERVOLTAGE_BIT 5
`define BUS_OVERCURRENT_BIT 4
`define DISCHARGE_OVERCURRENT_BIT 3
`define CONVERTER_OVERCURRENT_BIT 2
`define SECOND_INPUT_OVERVOLTAGE_BIT 1
`define FIRST_INPUT_OVERVOLTAGE_BIT 0

// Field positions in the first interrupt mask register.
`define INPUT_CURRENT_LIMIT_MASK_BIT 7
`define INPUT_VOLTAGE_LIMIT_MASK_BIT 6
`define WATCHDOG_EXPIRY_MASK_BIT 5
`define WEAK_SOURCE_MASK_BIT 4
`define POWER_GOOD_MASK_BIT 3
`define SECOND_INPUT_PRESENCE_MASK_BIT 2
`define FIRST_INPUT_PRESENCE_MASK_BIT 1
`define BUS_PRESENCE_MASK_BIT 0

// ==========================================================================
// Interrupt pulse width
`define IRQ_PULSE_NS 256
`define CLK_PERIOD_NS 10
`define IRQ_PULSE_CYCLES ((`IRQ_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: edge_sync.v */
// Three-stage synchroniser with rising and any-change detection for a vector of event levels.
// Assumes inputs come from outside the ref_clk domain.
`default_nettype none

module edge_sync #(
  parameter WIDTH = 8
) (
  input wire ref_clk,
  input wire reset_n,
  input wire [WIDTH-1:0] level_in,
  output wire [WIDTH-1:0] rise,
  output wire [WIDTH-1:0] change
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  reg [WIDTH-1:0] stable_q;
  wire [WIDTH-1:0] agreed;

  // ==========================================================================
  // Synchroniser chain; a new level is accepted once stages two and three agree.
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_q <= {WIDTH{1'b0}};
      s2_q <= {WIDTH{1'b0}};
      s3_q <= {WIDTH{1'b0}};
      stable_q <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_q <= level_in;
      s2_q <= meta_q;
      s3_q <= s2_q;
      stable_q <= agreed;
    end
  end

  // Edge terms derived from the accepted level only.
  assign agreed = (s2_q & s3_q) | (stable_q & (s2_q | s3_q));
  assign rise = agreed & ~stable_q;
  assign change = agreed ^ stable_q;

endmodule // edge_sync

`default_nettype wire

/* File: irq_pulser.v */
// Stretches a one-cycle interrupt request into a fixed-width active-low pulse.
// Assumes requests are single-cycle and arrive on ref_clk.
`default_nettype none

module irq_pulser #(
  parameter CYCLES = 26
) (
  input wire ref_clk,
  input wire reset_n,
  input wire request,
  output reg irq_n
);

  reg [15:0] count_q;

  // ==========================================================================
  // Restarts the pulse on every request so bursts merge into one longer pulse.
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_q <= 16'h0000;
      irq_n <= 1'b1;
    end
    else if (request)
    begin
      count_q <= CYCLES[15:0];
      irq_n <= 1'b0;
    end
    else if (count_q > 16'h0001)
    begin
      count_q <= count_q - 16'h0001;
      irq_n <= 1'b0;
    end
    else
    begin
      count_q <= 16'h0000;
      irq_n <= 1'b1;
    end
  end

endmodule // irq_pulser

`default_nettype wire

/* File: host_bus_model.sv */
// Host-side model driving the register strobes of the flag and mask bank.
// Assumes one bench process calls its tasks, each starting after a clock edge.
`default_nettype none
// ==========================================================================
// Host register access model
module host_bus_model (
  input wire logic ref_clk,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic [7:0] reg_addr,
  output logic reg_read,
  output logic reg_write,
  output logic [7:0] reg_wdata,
  output logic register_reset
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero.
  initial
  begin
    reg_addr = 8'h00;
    reg_read = 1'b0;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
    register_reset = 1'b0;
  end

  // One-cycle write; released lines then show the inverse, not stale values.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // One-cycle read; answer is taken at the edge after the strobe is seen.
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    @(posedge ref_clk);
    ok = reg_rvalid;
    d = reg_rdata;
  endtask

  // One-cycle register reset command.
  task automatic clear_masks();
    @(posedge ref_clk);
    register_reset <= 1'b1;
    @(posedge ref_clk);
    register_reset <= 1'b0;
  endtask
endmodule // host_bus_model
`default_nettype wire

/* File: charger_fault_flag_mask_bank_chk.sv */
// Concurrent checks on the ports of the flag and mask bank.
// Assumes a single ref_clk domain with active-low asynchronous reset.
`default_nettype none
// ==========================================================================
// Checker
module flag_bank_checker #(
  parameter int IRQ_CYCLES = 26
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_read,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic register_reset,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic irq_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] low_cnt_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // Counts consecutive cycles with the interrupt line low.
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
      low_cnt_q <= 16'h0000;
    else if (irq_n)
      low_cnt_q <= 16'h0000;
    else
      low_cnt_q <= low_cnt_q + 16'h0001;

  read_answer_a: assert property (reg_read |=> reg_rvalid)
    else $error("read strobe not answered next cycle");
  answer_cause_a: assert property (reg_rvalid |-> $past(reg_read))
    else $error("read answer without a read strobe");
  mask_readback_a: assert property ((reg_write && !register_reset && reg_addr == 8'h28)
    ##1 (!register_reset && !reg_write)
    ##1 (reg_read && !reg_write && !register_reset && reg_addr == 8'h28) |=> reg_rdata == $past(reg_wdata, 3))
    else $error("mask register did not return written value");
  mask_cleared_a: assert property (register_reset ##1 (!reg_write && !register_reset)
    ##1 (reg_read && !reg_write && reg_addr == 8'h28) |=> reg_rdata == 8'h00)
    else $error("mask not cleared by register reset");
  flags_reserved_a: assert property (reg_rvalid && $past(reg_addr) == 8'h25 |-> reg_rdata[7:5] == 3'h0)
    else $error("reserved charger flag bits not zero");
  fault_reserved_a: assert property (reg_rvalid && $past(reg_addr) == 8'h27 |->
    reg_rdata[3] == 1'b0 && reg_rdata[1:0] == 2'h0)
    else $error("reserved fault flag bits not zero");
  unmapped_zero_a: assert property (reg_rvalid && ($past(reg_addr) < 8'h25 || $past(reg_addr) > 8'h28) |->
    reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  irq_width_a: assert property ($rose(irq_n) |-> low_cnt_q >= IRQ_CYCLES)
    else $error("interrupt pulse too short");
endmodule // flag_bank_checker

bind charger_fault_flag_mask_bank flag_bank_checker #(.IRQ_CYCLES(IRQ_CYCLES)) chk_i (
  .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_read(reg_read), .reg_write(reg_write),
  .reg_wdata(reg_wdata), .register_reset(register_reset), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .irq_n(irq_n));
`default_nettype wire

/* File: charger_fault_flag_mask_bank_tb_top.sv */
// Self-checking bench for the flag and mask bank.
// Assumes host_bus_model drives the register strobes.
`default_nettype none
// ==========================================================================
// Bench top
module charger_fault_flag_mask_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk;
  logic reset_n;
  logic [17:0] f;
  logic [7:0] m;
  wire logic [7:0] reg_addr, reg_wdata, reg_rdata;
  wire logic reg_read, reg_write, register_reset, reg_rvalid, irq_n;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;

  charger_fault_flag_mask_bank #(.IRQ_CYCLES(4)) dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
    .reg_wdata(reg_wdata), .register_reset(register_reset), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .battery_low_for_boost(f[4]), .thermistor_cold(f[3]), .thermistor_cool(f[2]), .thermistor_warm(f[1]),
    .thermistor_hot(f[0]), .battery_current_regulation(f[12]), .bus_overvoltage(f[11]),
    .battery_overvoltage(f[10]), .bus_overcurrent(f[9]), .discharge_overcurrent(f[8]),
    .converter_overcurrent(f[7]), .second_input_overvoltage(f[6]), .first_input_overvoltage(f[5]),
    .system_short(f[17]), .system_overvoltage(f[16]), .boost_overvoltage(f[15]), .boost_undervoltage(f[14]),
    .die_thermal_shutdown(f[13]), .input_current_limit(m[7]), .input_voltage_limit(m[6]),
    .watchdog_expired(m[5]), .weak_source(m[4]), .power_good(m[3]), .second_input_present(m[2]),
    .first_input_present(m[1]), .bus_present(m[0]), .irq_n(irq_n));

  host_bus_model host (
    .ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_addr(reg_addr),
    .reg_read(reg_read), .reg_write(reg_write), .reg_wdata(reg_wdata), .register_reset(register_reset));

  // Free-running 100 MHz clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    $display("checks=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Reads a register and compares both the answer strobe and the data.
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    host.rd(a, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, e);
  endtask

  // Watches long enough for synchroniser, flag and whole pulse to pass.
  task automatic irq_wait(output logic s);
    s = 1'b0;
    repeat (12) @(posedge ref_clk) if (irq_n === 1'b0) s = 1'b1;
  endtask

  task automatic t_reset_values();
    rc(8'h25, 8'h00);
    rc(8'h26, 8'h00);
    rc(8'h27, 8'h00);
    rc(8'h28, 8'h00);
    rc(8'h29, 8'h00);
  endtask

  task automatic t_mask_rw();
    host.wr(8'h28, 8'ha5);
    rc(8'h28, 8'ha5);
    host.wr(8'h25, 8'hff);
    rc(8'h25, 8'h00);
    host.clear_masks();
    rc(8'h28, 8'h00);
  endtask

  // Each flag: rise sets it and pulses, read clears it, fall sets only change-type flags.
  task automatic t_flag_events();
    logic [7:0] a;
    logic [7:0] b;
    logic s;
    logic any;
    for (int i = 0; i < 18; i++)
    begin
      a = (i < 5) ? 8'h25 : (i < 13) ? 8'h26 : 8'h27;
      b = 8'h01 << ((i < 5) ? i : (i < 13) ? i - 5 : (i == 13) ? 2 : i - 10);
      any = (i < 4 || i == 12);
      @(posedge ref_clk);
      f[i] <= 1'b1;
      irq_wait(s);
      chk({7'h00, s}, 8'h01);
      rc(a, b);
      rc(a, 8'h00);
      @(posedge ref_clk);
      f[i] <= 1'b0;
      irq_wait(s);
      chk({7'h00, s}, {7'h00, any});
      rc(a, any ? b : 8'h00);
    end
  endtask

  // Each mask bit: unmasked rise and change pulse, masked events stay silent.
  task automatic t_mask_events();
    logic s;
    for (int j = 0; j < 8; j++)
    begin
      for (int k = 0; k < 4; k++)
      begin
        if (k == 2)
          host.wr(8'h28, 8'h01 << j);
        @(posedge ref_clk);
        m[j] <= (k % 2 == 0);
        irq_wait(s);
        chk({7'h00, s}, {7'h00, k == 0 || (k == 1 && j < 4)});
      end
      host.clear_masks();
    end
  endtask

  // Cuts a hang short.
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      print_verdict();
    end
  end

  // Main sequence.
  initial
  begin
    reset_n = 1'b0;
    f = 18'h00000;
    m = 8'h00;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_reset_values();
    t_mask_rw();
    t_flag_events();
    t_mask_events();
    print_verdict();
  end
endmodule // charger_fault_flag_mask_bank_tb_top
`default_nettype wire
